//--- verilog/bridge_secondary_pin_functions.sv
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module bridge_secondary_pin_functions
   import pin_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   input wire logic external_reset_input_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Secondary bus request and grant
   input wire logic [NUM_MASTERS-1:0] request_n,
   output logic [NUM_MASTERS-1:0] grant_n,
   // Bridge own bus request
   input wire logic own_bus_request,
   output logic own_bus_granted,
   // Multipurpose pins
   input wire logic [NUM_PINS-1:0] gpio_in,
   output logic [NUM_PINS-1:0] gpio_out,
   output logic [NUM_PINS-1:0] gpio_oe_n,
   // Straps
   input wire logic [1:0] operation_mode_straps,
   input wire logic clock_run_enable_strap,
   input wire logic bus_speed_select,
   // Clock-run line
   input wire logic clock_run_line_in,
   output logic clock_run_line_out,
   output logic clock_run_line_oe_n
);
   logic [SY_W-1:0] sync_q;
   logic rst;
   logic [NUM_MASTERS-1:0] req_act;
   logic pin6_in_s;
   logic [1:0] mode_s;
   logic cr_en_s;
   logic speed_s;
   logic cr_line_s;
   logic captured_r;
   logic [1:0] mode_r;
   logic [31:0] option_r;
   logic arb_en;
   logic clk_stop;
   logic [NUM_CLK_PINS-1:0] clk_mask;
   logic [NUM_CLK_PINS-1:0] gpio_val;
   logic [NUM_MASTERS-1:0] grant_n_r;
   logic [NUM_MASTERS-1:0] gnt_nxt;
   logic own_granted_r;
   cr_state_t cr_state_r;
   cr_state_t cr_state_nxt;
   logic [4:0] cr_cnt_r;
   logic [4:0] cr_cnt_nxt;
   logic cr_out_r;
   logic cr_out_nxt;
   logic cr_oe_n_r;
   logic cr_oe_n_nxt;
   logic clk_run;
   logic [NUM_PINS-1:0] pin_out_r;
   logic [NUM_PINS-1:0] pin_out_nxt;
   logic [NUM_PINS-1:0] pin_oe_n_r;
   logic [NUM_PINS-1:0] pin_oe_n_nxt;
   logic [3:0] test_sig;
   logic [31:0] status;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic hit;
   logic wr_opt;

   pin_clk_if clk_bus ();

   // ==========================================================
   // Pin synchronisers and reset
   pin_sync #(.WIDTH(SY_W)) u_sync (
      .clock(clock),
      .d({external_reset_input_n, clock_run_line_in, bus_speed_select,
          clock_run_enable_strap, operation_mode_straps, gpio_in[NUM_PINS-1], request_n}),
      .q(sync_q)
   );

   assign rst = reset || !sync_q[SY_RST_N];
   assign req_act = ~sync_q[SY_REQ_LSB +: NUM_MASTERS];
   assign pin6_in_s = sync_q[SY_PIN6];
   assign mode_s = sync_q[SY_MODE_LSB +: 2];
   assign cr_en_s = sync_q[SY_CR_EN];
   assign speed_s = sync_q[SY_SPEED];
   assign cr_line_s = sync_q[SY_CR_IN];

   // ==========================================================
   // Mode straps caught once after reset release
   always_ff @(posedge clock) begin
      if (rst) begin
         captured_r <= 1'b0;
         mode_r <= MODE_NORMAL;
      end else if (!captured_r) begin
         captured_r <= 1'b1;
         mode_r <= mode_s;
      end
   end

   // ==========================================================
   // Option register fields
   assign arb_en = option_r[OPT_ARB_EN];
   assign clk_stop = option_r[OPT_CLK_STOP];
   assign clk_mask = option_r[OPT_MASK_LSB +: NUM_CLK_PINS];
   assign gpio_val = option_r[OPT_VAL_LSB +: NUM_CLK_PINS];

   // ==========================================================
   // Secondary bus arbiter, hold while requested, else lowest index
   always_comb begin
      gnt_nxt = ~grant_n_r & req_act;
      if (gnt_nxt == '0) begin
         for (int i = NUM_MASTERS - 1; i >= 0; i--) begin
            if (req_act[i]) begin
               gnt_nxt = '0;
               gnt_nxt[i] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         grant_n_r <= '1;
         own_granted_r <= 1'b0;
      end else if (!arb_en) begin
         grant_n_r <= {{(NUM_MASTERS-1){1'b1}}, ~own_bus_request};
         own_granted_r <= req_act[0];
      end else begin
         grant_n_r <= ~gnt_nxt;
         own_granted_r <= 1'b0;
      end
   end

   // ==========================================================
   // Clock-run handshake
   always_comb begin
      cr_state_nxt = cr_state_r;
      cr_cnt_nxt = cr_cnt_r;
      cr_out_nxt = 1'b1;
      cr_oe_n_nxt = 1'b1;
      case (cr_state_r)
         CR_IDLE: begin
            if (cr_cnt_r != 5'h0) begin
               cr_cnt_nxt = cr_cnt_r - 5'h1;
            end else if (cr_en_s && !cr_line_s) begin
               cr_state_nxt = CR_HOLD;
               cr_out_nxt = 1'b0;
               cr_oe_n_nxt = 1'b0;
            end
         end
         CR_HOLD: begin
            cr_out_nxt = 1'b0;
            cr_oe_n_nxt = 1'b0;
            if (cr_cnt_r != CR_HOLD_LAST) begin
               cr_cnt_nxt = cr_cnt_r + 5'h1;
            end
            if (!cr_en_s) begin
               cr_state_nxt = CR_IDLE;
               cr_cnt_nxt = 5'h0;
               cr_out_nxt = 1'b1;
               cr_oe_n_nxt = 1'b1;
            end else if (cr_cnt_r == CR_HOLD_LAST && clk_stop) begin
               cr_state_nxt = CR_RELEASE;
               cr_out_nxt = 1'b1;
            end
         end
         CR_RELEASE: begin
            cr_state_nxt = CR_IDLE;
            cr_cnt_nxt = CR_BLIND;
         end
         default: begin
            cr_state_nxt = CR_IDLE;
            cr_cnt_nxt = 5'h0;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cr_state_r <= CR_IDLE;
         cr_cnt_r <= 5'h0;
         cr_out_r <= 1'b1;
         cr_oe_n_r <= 1'b1;
      end else begin
         cr_state_r <= cr_state_nxt;
         cr_cnt_r <= cr_cnt_nxt;
         cr_out_r <= cr_out_nxt;
         cr_oe_n_r <= cr_oe_n_nxt;
      end
   end

   // ==========================================================
   // Bus clock generator
   assign clk_run = !(cr_en_s && clk_stop && cr_state_r == CR_IDLE);
   assign clk_bus.run = clk_run;
   assign clk_bus.fast = speed_s;

   pin_clock_gen u_clk (
      .clock(clock),
      .reset(rst),
      .bus(clk_bus)
   );

   // ==========================================================
   // Multipurpose pin selection
   assign test_sig = {own_granted_r, ~&grant_n_r, clk_bus.level, ~cr_oe_n_r};

   always_comb begin
      pin_out_nxt = '0;
      pin_oe_n_nxt = '1;
      case (mode_r)
         MODE_NORMAL: begin
            for (int i = 0; i < NUM_CLK_PINS; i++) begin
               pin_oe_n_nxt[i] = 1'b0;
               pin_out_nxt[i] = clk_mask[i] ? gpio_val[i] : clk_bus.level;
            end
            pin_out_nxt[NUM_PINS-1] = option_r[OPT_PIN6_VAL];
            pin_oe_n_nxt[NUM_PINS-1] = !option_r[OPT_PIN6_OE];
         end
         MODE_TEST: begin
            for (int i = TEST_LSB; i < NUM_PINS; i++) begin
               pin_oe_n_nxt[i] = 1'b0;
               pin_out_nxt[i] = test_sig[i-TEST_LSB];
            end
         end
         default: begin
            pin_out_nxt = '0;
            pin_oe_n_nxt = '1;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pin_out_r <= '0;
         pin_oe_n_r <= '1;
      end else begin
         pin_out_r <= pin_out_nxt;
         pin_oe_n_r <= pin_oe_n_nxt;
      end
   end

   // ==========================================================
   // APB slave
   assign hit = (paddr == OPTION_ADDR) || (paddr == STATUS_ADDR);
   assign wr_opt = psel && penable && pready_r && pwrite && paddr == OPTION_ADDR;

   always_comb begin
      status = '0;
      status[ST_MODE_LSB +: 2] = mode_r;
      status[ST_CR_EN] = cr_en_s;
      status[ST_SPEED] = speed_s;
      status[ST_PIN6_IN] = pin6_in_s;
      status[ST_CR_DRIVE] = ~cr_oe_n_r;
      status[ST_CLK_RUN] = clk_run;
      status[ST_GNT_LSB +: NUM_MASTERS] = ~grant_n_r;
      status[ST_REQ_LSB +: NUM_MASTERS] = req_act;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         option_r <= OPTION_RESET;
      end else if (wr_opt) begin
         for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
               option_r[8*b +: 8] <= pwdata[8*b +: 8] & OPTION_WMASK[8*b +: 8];
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end else begin
         pready_r <= psel && !penable;
         pslverr_r <= psel && !penable && !hit;
         if (psel && !penable) begin
            prdata_r <= (paddr == OPTION_ADDR) ? option_r :
                        (paddr == STATUS_ADDR) ? status : 32'h0000_0000;
         end
      end
   end

   // ==========================================================
   // Outputs
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign grant_n = grant_n_r;
   assign own_bus_granted = own_granted_r;
   assign gpio_out = pin_out_r;
   assign gpio_oe_n = pin_oe_n_r;
   assign clock_run_line_out = cr_out_r;
   assign clock_run_line_oe_n = cr_oe_n_r;

   // ==========================================================
   // Checks
   property p_grant_onehot;
      @(posedge clock) disable iff (rst)
      arb_en |-> $onehot0(~grant_n_r);
   endproperty
   a_grant_onehot: assert property (p_grant_onehot) else $error("two grants");

   property p_grant_cause;
      @(posedge clock) disable iff (rst)
      (arb_en && $past(arb_en) && grant_n_r != '1) |-> ((~grant_n_r & $past(req_act)) != '0);
   endproperty
   a_grant_cause: assert property (p_grant_cause) else $error("grant without request");

   property p_arb_off_idle;
      @(posedge clock) disable iff (rst)
      !arb_en |=> grant_n_r[NUM_MASTERS-1:1] == '1;
   endproperty
   a_arb_off_idle: assert property (p_arb_off_idle) else $error("grant while arbiter off");

   property p_own_request;
      @(posedge clock) disable iff (rst)
      !arb_en |=> grant_n_r[0] == !$past(own_bus_request);
   endproperty
   a_own_request: assert property (p_own_request) else $error("own request not on grant 0");

   property p_own_grant;
      @(posedge clock) disable iff (rst)
      !arb_en |=> own_granted_r == $past(req_act[0]);
   endproperty
   a_own_grant: assert property (p_own_grant) else $error("own grant not from request 0");

   property p_pin_clock;
      @(posedge clock) disable iff (rst)
      (mode_r == MODE_NORMAL && !clk_mask[0]) |=> !pin_oe_n_r[0] && pin_out_r[0] == $past(clk_bus.level);
   endproperty
   a_pin_clock: assert property (p_pin_clock) else $error("pin 0 not a clock");

   property p_pin_masked;
      @(posedge clock) disable iff (rst)
      (mode_r == MODE_NORMAL && clk_mask[4]) |=> !pin_oe_n_r[4] && pin_out_r[4] == $past(gpio_val[4]);
   endproperty
   a_pin_masked: assert property (p_pin_masked) else $error("masked pin wrong");

   property p_test_pins;
      @(posedge clock) disable iff (rst)
      (mode_r == MODE_TEST) |=> pin_oe_n_r == 7'h07 && pin_out_r[NUM_PINS-1] == $past(own_granted_r);
   endproperty
   a_test_pins: assert property (p_test_pins) else $error("test mode pins wrong");

   property p_pin6_gpio;
      @(posedge clock) disable iff (rst)
      (mode_r == MODE_NORMAL) |=> pin_oe_n_r[NUM_PINS-1] == !$past(option_r[OPT_PIN6_OE]);
   endproperty
   a_pin6_gpio: assert property (p_pin6_gpio) else $error("pin 6 enable wrong");

   property p_cr_disabled;
      @(posedge clock) disable iff (rst)
      (!cr_en_s) [*2] |-> cr_oe_n_r;
   endproperty
   a_cr_disabled: assert property (p_cr_disabled) else $error("clock-run driven while off");

   sequence s_cr_drive_low;
      !cr_oe_n_r && !cr_out_r;
   endsequence
   sequence s_cr_drive_high;
      !cr_oe_n_r && cr_out_r;
   endsequence
   property p_cr_release;
      @(posedge clock) disable iff (rst)
      s_cr_drive_low ##1 s_cr_drive_high |=> cr_oe_n_r;
   endproperty
   a_cr_release: assert property (p_cr_release) else $error("clock-run release wrong");

   property p_cr_answer;
      @(posedge clock) disable iff (rst)
      (cr_state_r == CR_IDLE && cr_cnt_r == 5'h0 && cr_en_s && !cr_line_s) |=> s_cr_drive_low;
   endproperty
   a_cr_answer: assert property (p_cr_answer) else $error("clock-run request not held");
endmodule
`default_nettype wire

//--- pkg/pin_pkg.sv
`default_nettype none
package pin_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int CR_HOLD_NS = 1000;
   localparam int CR_HOLD_CYC = (CR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] CR_HOLD_LAST = 5'(CR_HOLD_CYC - 1);
   localparam logic [4:0] CR_BLIND = 5'h3;
   localparam logic [1:0] HALF_FAST = 2'h1;
   localparam logic [1:0] HALF_SLOW = 2'h2;
   // ==========================================================
   // Sizes and modes
   localparam int NUM_MASTERS = 5;
   localparam int NUM_PINS = 7;
   localparam int NUM_CLK_PINS = 6;
   localparam int TEST_LSB = 3;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_TEST = 2'h1;
   // ==========================================================
   // Register map
   localparam logic [11:0] OPTION_ADDR = 12'h000;
   localparam logic [11:0] STATUS_ADDR = 12'h004;
   localparam logic [31:0] OPTION_RESET = 32'h0000_0001;
   localparam logic [31:0] OPTION_WMASK = 32'h033f_3f03;
   localparam int OPT_ARB_EN = 0;
   localparam int OPT_CLK_STOP = 1;
   localparam int OPT_MASK_LSB = 8;
   localparam int OPT_VAL_LSB = 16;
   localparam int OPT_PIN6_VAL = 24;
   localparam int OPT_PIN6_OE = 25;
   localparam int ST_MODE_LSB = 0;
   localparam int ST_CR_EN = 2;
   localparam int ST_SPEED = 3;
   localparam int ST_PIN6_IN = 4;
   localparam int ST_CR_DRIVE = 5;
   localparam int ST_CLK_RUN = 6;
   localparam int ST_GNT_LSB = 8;
   localparam int ST_REQ_LSB = 16;
   // ==========================================================
   // Synchroniser vector layout
   localparam int SY_REQ_LSB = 0;
   localparam int SY_PIN6 = 5;
   localparam int SY_MODE_LSB = 6;
   localparam int SY_CR_EN = 8;
   localparam int SY_SPEED = 9;
   localparam int SY_CR_IN = 10;
   localparam int SY_RST_N = 11;
   localparam int SY_W = 12;
   typedef enum logic [1:0] {CR_IDLE, CR_HOLD, CR_RELEASE} cr_state_t;
endpackage
`default_nettype wire

//--- pkg/pin_clk_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pin_clk_if;
   logic run;
   logic fast;
   logic level;
   modport gen (input run, input fast, output level);
   modport user (output run, output fast, input level);
endinterface
`default_nettype wire

//--- verilog/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(parameter int WIDTH = 1) (
   // Clock
   input wire logic clock,
   // Data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   // ==========================================================
   // Two-stage synchroniser
   always_ff @(posedge clock) begin
      meta_r <= d;
      q <= meta_r;
   end
endmodule
`default_nettype wire

//--- verilog/pin_clock_gen.sv
`timescale 1ns/100ps
`default_nettype none
module pin_clock_gen
   import pin_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Control and level
   pin_clk_if.gen bus
);
   logic [1:0] cnt_r;
   logic [1:0] half;
   logic level_r;

   assign half = bus.fast ? HALF_FAST : HALF_SLOW;
   assign bus.level = level_r;

   // ==========================================================
   // Divider, held low while stopped
   always_ff @(posedge clock) begin
      if (reset || !bus.run) begin
         cnt_r <= 2'h0;
         level_r <= 1'b0;
      end else if (cnt_r >= half - 2'h1) begin
         cnt_r <= 2'h0;
         level_r <= ~level_r;
      end else begin
         cnt_r <= cnt_r + 2'h1;
      end
   end

   // ==========================================================
   // Checks
   property p_fast_rate;
      @(posedge clock) disable iff (reset)
      (bus.run && bus.fast) [*3] |-> level_r != $past(level_r);
   endproperty
   a_fast_rate: assert property (p_fast_rate) else $error("fast clock not toggling");

   property p_slow_rate;
      @(posedge clock) disable iff (reset)
      (bus.run && !bus.fast) [*6] |-> level_r != $past(level_r, 2) && level_r == $past(level_r, 4);
   endproperty
   a_slow_rate: assert property (p_slow_rate) else $error("slow clock rate wrong");
endmodule
`default_nettype wire

//--- verification/bus_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Secondary masters and clock-run pull
module bus_partner (
   // Clock
   input wire logic clock,
   // Bench commands
   input wire logic [4:0] want,
   input wire logic pull,
   // Clock-run wire
   input wire logic cr_out,
   input wire logic cr_oe_n,
   output logic cr_line,
   // Requests
   output logic [4:0] request_n
);
   logic pull_r;
   always @(posedge clock) begin
      request_n <= ~want;
      pull_r <= pull;
   end
   // Pull-up wins when nobody drives
   assign cr_line = (cr_oe_n ? 1'b1 : cr_out) & ~pull_r;
endmodule
`default_nettype wire

//--- verification/bridge_secondary_pin_functions_tb.sv
`timescale 1ns/100ps
`default_nettype none
module bridge_secondary_pin_functions_tb
   import pin_pkg::*;
();
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic external_reset_input_n = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [4:0] request_n;
   logic [4:0] grant_n;
   logic own_bus_request = 1'b0;
   logic own_bus_granted;
   logic [6:0] gpio_in = 7'h0;
   logic [6:0] gpio_out;
   logic [6:0] gpio_oe_n;
   logic [6:0] prev;
   logic [1:0] mode = 2'h0;
   logic cr_en = 1'b1;
   logic speed = 1'b1;
   logic cr_line;
   logic cr_out;
   logic cr_oe_n;
   logic [4:0] want = 5'h0;
   logic [4:0] r;
   logic [4:0] lo;
   logic pull = 1'b0;
   logic [31:0] seed = 32'h000174dc;
   logic [31:0] rd;
   logic [31:0] opt;
   logic [31:0] d;
   logic err;
   int error_cnt = 0;
   int compares = 0;
   int n;
   int t;

   always #(CLK_PERIOD_NS / 2) clock = ~clock;

   bridge_secondary_pin_functions dut_u (.clock(clock), .reset(reset),
      .external_reset_input_n(external_reset_input_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .request_n(request_n), .grant_n(grant_n),
      .own_bus_request(own_bus_request), .own_bus_granted(own_bus_granted),
      .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
      .operation_mode_straps(mode), .clock_run_enable_strap(cr_en),
      .bus_speed_select(speed), .clock_run_line_in(cr_line),
      .clock_run_line_out(cr_out), .clock_run_line_oe_n(cr_oe_n));

   bus_partner partner_u (.clock(clock), .want(want), .pull(pull), .cr_out(cr_out),
      .cr_oe_n(cr_oe_n), .cr_line(cr_line), .request_n(request_n));

   // ==========================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, x, input logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return ((o & ~m) | (x & m)) & OPTION_WMASK;
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      compares++;
      if (g !== e) begin
         $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
         error_cnt++;
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] x,
                      input logic [3:0] s);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= x;
      pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk(32'(n < 20), 32'h1, "apb answer");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic do_reset();
      reset <= 1'b1;
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      repeat (4) @(posedge clock);
   endtask

   task automatic results();
      if (error_cnt == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #(CLK_PERIOD_NS * 20000);
      $display("wrong value at %0t: timeout", $time);
      error_cnt++;
      results();
   end

   // ==========================================
   // Scenarios
   initial begin
      do_reset();
      apb(1'b0, OPTION_ADDR, 32'h0, 4'h0);
      chk(rd, OPTION_RESET, "option reset");
      chk(32'(gpio_oe_n), 32'h40, "pins driven");
      for (int sp = 0; sp < 2; sp++) begin
         speed <= sp[0];
         repeat (8) @(posedge clock);
         t = 0;
         prev = gpio_out;
         repeat (16) begin
            @(posedge clock);
            t += int'(gpio_out[0] != prev[0]) + int'(gpio_out[5] != prev[5]);
            prev = gpio_out;
         end
         chk(32'(t), sp ? 32'h20 : 32'h10, "clock toggles");
      end
      opt = OPTION_RESET;
      for (int k = 0; k < 6; k++) begin
         d = rnd() & ~32'h2;
         r = 5'(rnd());
         apb(1'b1, OPTION_ADDR, d, r[3:0]);
         opt = merge(opt, d, r[3:0]);
         apb(1'b0, OPTION_ADDR, 32'h0, 4'h0);
         chk(rd, opt, "option readback");
         chk(32'(gpio_out[5:0] & opt[13:8]), 32'(opt[21:16] & opt[13:8]), "gpio");
         chk(32'(gpio_oe_n), {25'h0, ~opt[25], 6'h0}, "gpio oe");
         if (opt[25]) begin
            chk(32'(gpio_out[6]), 32'(opt[24]), "pin6 out");
         end
         gpio_in <= 7'(rnd());
         repeat (4) @(posedge clock);
         apb(1'b0, STATUS_ADDR, 32'h0, 4'h0);
         chk(32'(rd[ST_PIN6_IN]), 32'(gpio_in[6]), "pin6 in");
      end
      d = rnd();
      apb(1'b0, {d[11:4], 4'h8}, 32'h0, 4'h0);
      chk({rd[30:0], err}, 32'h1, "unmapped read");
      apb(1'b1, STATUS_ADDR, 32'hffff_ffff, 4'hf);
      chk(32'(err), 32'h0, "status write");
      apb(1'b1, OPTION_ADDR, 32'h1, 4'hf);
      for (int k = 0; k < 8; k++) begin
         want <= 5'h0;
         repeat (6) @(posedge clock);
         r = 5'(rnd());
         r = (r == 5'h0) ? 5'h3 : r;
         lo = r & -r;
         want <= r;
         for (n = 0; n < 10 && grant_n === 5'h1f; n++) @(posedge clock);
         chk(32'(grant_n), {27'h0, ~lo}, "grant");
         r = r & ~lo;
         lo = r & -r;
         want <= r;
         repeat (6) @(posedge clock);
         chk(32'(grant_n), {27'h0, ~lo}, "regrant");
      end
      apb(1'b1, OPTION_ADDR, 32'h0, 4'hf);
      want <= 5'h1e;
      own_bus_request <= 1'b1;
      repeat (6) @(posedge clock);
      chk(32'(grant_n), 32'h1e, "own request");
      own_bus_request <= 1'b0;
      want <= 5'h01;
      repeat (6) @(posedge clock);
      chk(32'({grant_n, own_bus_granted}), 32'h3f, "own grant");
      want <= 5'h0;
      pull <= 1'b1;
      repeat (2) @(posedge clock);
      pull <= 1'b0;
      for (n = 0; n < 8 && cr_oe_n !== 1'b0; n++) @(posedge clock);
      chk(32'({cr_oe_n, cr_out}), 32'h0, "clock-run hold");
      repeat (40) @(posedge clock);
      chk(32'({cr_oe_n, cr_out}), 32'h0, "clock-run still");
      apb(1'b1, OPTION_ADDR, 32'h3, 4'hf);
      for (n = 0; n < 60 && cr_out !== 1'b1; n++) @(posedge clock);
      chk(32'({cr_oe_n, cr_out}), 32'h1, "clock-run high");
      repeat (2) @(posedge clock);
      chk(32'(cr_oe_n), 32'h1, "clock-run release");
      cr_en <= 1'b0;
      repeat (5) @(posedge clock);
      pull <= 1'b1;
      t = 0;
      repeat (10) begin
         @(posedge clock);
         t |= int'(!cr_oe_n);
      end
      chk(32'(t), 32'h0, "strap off");
      pull <= 1'b0;
      cr_en <= 1'b1;
      external_reset_input_n <= 1'b0;
      repeat (5) @(posedge clock);
      chk(32'({grant_n, gpio_oe_n}), 32'hfff, "ext reset");
      external_reset_input_n <= 1'b1;
      repeat (4) @(posedge clock);
      apb(1'b0, OPTION_ADDR, 32'h0, 4'h0);
      chk(rd, OPTION_RESET, "ext reset option");
      mode <= MODE_TEST;
      do_reset();
      want <= 5'h02;
      repeat (8) @(posedge clock);
      chk(32'(gpio_oe_n), 32'h07, "test oe");
      chk(32'(gpio_out[6:5]), 32'h1, "test out");
      apb(1'b0, STATUS_ADDR, 32'h0, 4'h0);
      chk(32'(rd[1:0]), 32'(MODE_TEST), "mode");
      mode <= 2'h2;
      do_reset();
      chk(32'(gpio_oe_n), 32'h7f, "mode released");
      results();
   end
endmodule
`default_nettype wire
